// File: tqu_target_attribute_query_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tqu_map.svh"

module tqu_target_attribute_query_unit (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Query request from the pipeline.
	input wire logic query_valid,
	input wire tqu_pkg::tqu_req_s query_req,
	input wire tqu_pkg::tqu_ctx_s query_ctx,
	// Lookup request to the units.
	output logic [31:0] lookup_addr,
	output logic lookup_priv,
	output logic lookup_use_ns_mpu,
	// Lookup results for lookup_addr, same cycle.
	input wire tqu_pkg::tqu_mpu_s mpu_s_res,
	input wire tqu_pkg::tqu_mpu_s mpu_ns_res,
	input wire tqu_pkg::tqu_mpu_s mpu_ns_unpriv_res,
	input wire tqu_pkg::tqu_attr_s sau_res,
	input wire tqu_pkg::tqu_attr_s impl_defined_attribution_unit_res,
	// Response to the register file.
	output logic resp_valid,
	output tqu_pkg::tqu_resp_s resp,
	output logic undef_fault
);

	////////////////////////////////////////////////////////////////////////////////

	logic alt_var;
	logic force_unpriv_check_flag;
	logic use_nonsec_prot_unit_flag;
	logic cur_priv;
	logic eff_priv;
	logic illegal;
	tqu_pkg::tqu_mpu_s sel_mpu;
	tqu_pkg::tqu_mpu_s mpu_nsv;
	logic [31:0] word_d;
	logic resp_valid_q;
	logic undef_q;
	tqu_pkg::tqu_resp_s resp_q;

	assign alt_var = query_req.variant[1];
	assign force_unpriv_check_flag = query_req.variant[0];
	assign use_nonsec_prot_unit_flag = alt_var | ~query_ctx.secure_state;
	assign illegal = alt_var & ~query_ctx.secure_state;

	// Privilege from mode and the thread bit of the consulted state.
	always_comb begin
		if (use_nonsec_prot_unit_flag) begin
			cur_priv = query_ctx.handler_mode | ~query_ctx.unpriv_thread_bit_ns;
		end else begin
			cur_priv = query_ctx.handler_mode | ~query_ctx.unpriv_thread_bit_s;
		end
		eff_priv = cur_priv & ~force_unpriv_check_flag;
	end

	assign lookup_addr = query_req.addr;
	assign lookup_priv = eff_priv;
	assign lookup_use_ns_mpu = use_nonsec_prot_unit_flag;

	// Non-secure view: privileged or unprivileged answer.
	always_comb begin
		if (eff_priv) begin
			mpu_nsv = mpu_ns_res;
		end else begin
			mpu_nsv = mpu_ns_unpriv_res;
		end
		if (use_nonsec_prot_unit_flag) begin
			sel_mpu = mpu_nsv;
		end else begin
			sel_mpu = mpu_s_res;
		end
	end

	// Region number field, zero when the unit reports no hit.
	function automatic logic [7:0] region_field(logic hit, logic [7:0] region);
		return hit ? region : 8'h00;
	endfunction : region_field

	// Pack the response word.
	always_comb begin
		word_d = `TQU_RESP_RESET;
		word_d[`TQU_RESP_MPU_REGION_LSB +: 8] = region_field(sel_mpu.hit, sel_mpu.region);
		word_d[`TQU_RESP_MPU_VALID_BIT] = sel_mpu.hit;
		word_d[`TQU_RESP_READ_OK_BIT] = sel_mpu.read_ok;
		word_d[`TQU_RESP_RW_OK_BIT] = sel_mpu.rw_ok;
		if (query_ctx.secure_state) begin
			word_d[`TQU_RESP_SAU_REGION_LSB +: 8] = region_field(sau_res.hit, sau_res.region);
			word_d[`TQU_RESP_SAU_VALID_BIT] = sau_res.hit;
			word_d[`TQU_RESP_IMPL_DEFINED_ATTRIBUTION_UNIT_REGION_LSB +: 8] = region_field(impl_defined_attribution_unit_res.hit, impl_defined_attribution_unit_res.region);
			word_d[`TQU_RESP_IMPL_DEFINED_ATTRIBUTION_UNIT_VALID_BIT] = impl_defined_attribution_unit_res.hit;
			word_d[`TQU_RESP_SECURE_BIT] = sau_res.secure | impl_defined_attribution_unit_res.secure;
			word_d[`TQU_RESP_NONSEC_READ_BIT] = sel_mpu.read_ok & ~word_d[`TQU_RESP_SECURE_BIT];
			word_d[`TQU_RESP_NONSEC_RW_BIT] = sel_mpu.rw_ok & ~word_d[`TQU_RESP_SECURE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			resp_valid_q <= 1'b0;
			undef_q <= 1'b0;
		end else begin
			resp_valid_q <= query_valid & ~illegal;
			undef_q <= query_valid & illegal;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			resp_q.dest_reg <= 4'h0;
			resp_q.query_response_word <= `TQU_RESP_RESET;
		end else if (query_valid & ~illegal) begin
			resp_q.dest_reg <= query_req.dest_reg;
			resp_q.query_response_word <= word_d;
		end
	end

	assign resp_valid = resp_valid_q;
	assign undef_fault = undef_q;
	assign resp = resp_q;

	////////////////////////////////////////////////////////////////////////////////

	fault_excl_a: assert property (@(posedge core_clk) disable iff (reset)
		!(resp_valid && undef_fault))
		else $error("Response and fault together.");
	alt_ns_undef_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_req.variant[1] && !query_ctx.secure_state
		|=> undef_fault && !resp_valid)
		else $error("Alternate query from non-secure.");
	resp_one_cycle_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal
		|=> resp_valid)
		else $error("Missing response.");
	no_spurious_a: assert property (@(posedge core_clk) disable iff (reset)
		!query_valid
		|=> !resp_valid && !undef_fault)
		else $error("Spurious output.");
	resp_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		!(query_valid && !illegal)
		|=> $stable(resp))
		else $error("Response changed without a query.");
	dest_reg_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal
		|=> resp.dest_reg == $past(query_req.dest_reg))
		else $error("Destination register mismatch.");

	secure_plain_unit_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_req.variant == tqu_pkg::TQU_PLAIN && query_ctx.secure_state
		|-> !lookup_use_ns_mpu)
		else $error("Secure plain query used the wrong unit.");
	unpriv_lookup_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_req.variant[0]
		|-> !lookup_priv)
		else $error("Unpriv not forced.");
	alt_ns_mpu_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_req.variant[1]
		|-> lookup_use_ns_mpu)
		else $error("Wrong unit.");
	alt_unpriv_view_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_req.variant == tqu_pkg::TQU_ALT_UNPRIV && query_ctx.secure_state
		|=> resp.query_response_word[`TQU_RESP_READ_OK_BIT] == $past(mpu_ns_unpriv_res.read_ok))
		else $error("Alternate unprivileged view mismatch.");
	handler_priv_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_req.variant == tqu_pkg::TQU_PLAIN && query_ctx.handler_mode
		|-> lookup_priv)
		else $error("Handler not privileged.");
	thread_bit_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !query_req.variant[0] && !query_ctx.handler_mode
		|-> lookup_priv == (lookup_use_ns_mpu ? !query_ctx.unpriv_thread_bit_ns
		: !query_ctx.unpriv_thread_bit_s))
		else $error("Thread privilege mismatch.");

	read_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal
		|=> resp.query_response_word[`TQU_RESP_READ_OK_BIT] == $past(lookup_use_ns_mpu
		? (lookup_priv ? mpu_ns_res.read_ok : mpu_ns_unpriv_res.read_ok) : mpu_s_res.read_ok))
		else $error("Read flag mismatch.");
	rw_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal
		|=> resp.query_response_word[`TQU_RESP_RW_OK_BIT] == $past(lookup_use_ns_mpu
		? (lookup_priv ? mpu_ns_res.rw_ok : mpu_ns_unpriv_res.rw_ok) : mpu_s_res.rw_ok))
		else $error("Read-write flag mismatch.");
	secure_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_ctx.secure_state
		|=> resp.query_response_word[`TQU_RESP_SECURE_BIT] == $past(sau_res.secure | impl_defined_attribution_unit_res.secure))
		else $error("Secure flag mismatch.");
	mpu_region_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal && !lookup_use_ns_mpu && mpu_s_res.hit
		|=> resp.query_response_word[`TQU_RESP_MPU_REGION_LSB +: 8] == $past(mpu_s_res.region))
		else $error("Protection region mismatch.");
	region_num_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal && query_ctx.secure_state && sau_res.hit
		|=> resp.query_response_word[`TQU_RESP_SAU_REGION_LSB +: 8] == $past(sau_res.region))
		else $error("Region number mismatch.");
	impl_defined_attribution_unit_region_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && query_ctx.secure_state && impl_defined_attribution_unit_res.hit
		|=> resp.query_response_word[`TQU_RESP_IMPL_DEFINED_ATTRIBUTION_UNIT_REGION_LSB +: 8] == $past(impl_defined_attribution_unit_res.region))
		else $error("Fixed attribution region mismatch.");
	ns_state_attr_a: assert property (@(posedge core_clk) disable iff (reset)
		query_valid && !illegal && !query_ctx.secure_state
		|=> !resp.query_response_word[`TQU_RESP_SECURE_BIT]
		&& !resp.query_response_word[`TQU_RESP_SAU_VALID_BIT]
		&& !resp.query_response_word[`TQU_RESP_IMPL_DEFINED_ATTRIBUTION_UNIT_VALID_BIT])
		else $error("Attribution shown to non-secure query.");

	plain_c: cover property (@(posedge core_clk)
		query_valid && query_req.variant == tqu_pkg::TQU_PLAIN);
	unpriv_c: cover property (@(posedge core_clk)
		query_valid && query_req.variant == tqu_pkg::TQU_UNPRIV);
	alt_c: cover property (@(posedge core_clk)
		query_valid && query_req.variant[1] && !illegal);
	alt_unpriv_c: cover property (@(posedge core_clk)
		query_valid && query_req.variant == tqu_pkg::TQU_ALT_UNPRIV && !illegal);
	undef_c: cover property (@(posedge core_clk)
		undef_fault);

endmodule : tqu_target_attribute_query_unit
`default_nettype wire

// File: tqu_map.svh
`ifndef TQU_MAP_SVH
`define TQU_MAP_SVH

// Query variant encodings on the request port.
`define TQU_VAR_PLAIN 2'h0
`define TQU_VAR_UNPRIV 2'h1
`define TQU_VAR_ALT 2'h2
`define TQU_VAR_ALT_UNPRIV 2'h3

// Response word field positions.
`define TQU_RESP_MPU_REGION_LSB 0
`define TQU_RESP_SAU_REGION_LSB 8
`define TQU_RESP_MPU_VALID_BIT 16
`define TQU_RESP_SAU_VALID_BIT 17
`define TQU_RESP_READ_OK_BIT 18
`define TQU_RESP_RW_OK_BIT 19
`define TQU_RESP_NONSEC_READ_BIT 20
`define TQU_RESP_NONSEC_RW_BIT 21
`define TQU_RESP_SECURE_BIT 22
`define TQU_RESP_IMPL_DEFINED_ATTRIBUTION_UNIT_VALID_BIT 23
`define TQU_RESP_IMPL_DEFINED_ATTRIBUTION_UNIT_REGION_LSB 24

// Reset values.
`define TQU_RESP_RESET 32'h0000_0000

`endif

// File: tqu_pkg.sv
`default_nettype none
package tqu_pkg;

	typedef enum logic [1:0] {
		TQU_PLAIN = 2'h0,
		TQU_UNPRIV = 2'h1,
		TQU_ALT = 2'h2,
		TQU_ALT_UNPRIV = 2'h3
	} tqu_variant_e;

	// One query from the execution pipeline.
	typedef struct packed {
		tqu_variant_e variant;
		logic [31:0] addr;
		logic [3:0] dest_reg;
	} tqu_req_s;

	// Execution context of the requester.
	typedef struct packed {
		logic secure_state;
		logic handler_mode;
		logic unpriv_thread_bit_s;
		logic unpriv_thread_bit_ns;
	} tqu_ctx_s;

	// Lookup answer from one protection unit.
	typedef struct packed {
		logic hit;
		logic [7:0] region;
		logic read_ok;
		logic rw_ok;
	} tqu_mpu_s;

	// Lookup answer from one attribution unit.
	typedef struct packed {
		logic hit;
		logic [7:0] region;
		logic secure;
	} tqu_attr_s;

	// Completed query result.
	typedef struct packed {
		logic [3:0] dest_reg;
		logic [31:0] query_response_word;
	} tqu_resp_s;

endpackage : tqu_pkg
`default_nettype wire

// File: tqu_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module tqu_unit_model (
	// Lookup request.
	input wire logic [31:0] lookup_addr,
	input wire logic lookup_priv,
	// Unit answers.
	output tqu_pkg::tqu_mpu_s mpu_s_res,
	output tqu_pkg::tqu_mpu_s mpu_ns_res,
	output tqu_pkg::tqu_mpu_s mpu_ns_unpriv_res,
	output tqu_pkg::tqu_attr_s sau_res,
	output tqu_pkg::tqu_attr_s impl_defined_attribution_unit_res
);
	logic [31:0] a;
	assign a = lookup_addr;
	// Secure MPU regions come from a[15:8], both non-secure MPU views from a[23:16], SAU regions from a[31:24], the other attribution unit from ~a[31:24].
	assign mpu_s_res = {a[4], a[15:8], 1'b1, lookup_priv};
	assign mpu_ns_res = {a[5], a[23:16], 2'h3};
	assign mpu_ns_unpriv_res = {a[5], a[23:16], a[6], 1'b0};
	assign sau_res = {a[7], a[31:24], a[1]};
	assign impl_defined_attribution_unit_res = {a[3], ~a[31:24], a[2]};
endmodule : tqu_unit_model
`default_nettype wire

// File: tqu_target_attribute_query_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module tqu_target_attribute_query_unit_test;
	logic core_clk = 0;
	logic reset = 1;
	logic query_valid = 0;
	tqu_pkg::tqu_req_s query_req = '0;
	tqu_pkg::tqu_ctx_s query_ctx = '0;
	logic [31:0] lookup_addr;
	logic lookup_priv, lookup_use_ns_mpu, resp_valid, undef_fault, ns, pv;
	tqu_pkg::tqu_mpu_s mpu_s_res, mpu_ns_res, mpu_ns_unpriv_res;
	tqu_pkg::tqu_attr_s sau_res, impl_defined_attribution_unit_res;
	tqu_pkg::tqu_resp_s resp, exp_resp;
	logic exp_valid = 0, exp_fault = 0;
	int n_mismatch = 0, checked = 0, cycles = 0;
	always #2.5 core_clk = ~core_clk;
	tqu_target_attribute_query_unit dut (.core_clk, .reset, .query_valid, .query_req,
		.query_ctx, .lookup_addr, .lookup_priv, .lookup_use_ns_mpu, .mpu_s_res, .mpu_ns_res,
		.mpu_ns_unpriv_res, .sau_res, .impl_defined_attribution_unit_res, .resp_valid, .resp, .undef_fault);
	tqu_unit_model units (.lookup_addr, .lookup_priv, .mpu_s_res, .mpu_ns_res,
		.mpu_ns_unpriv_res, .sau_res, .impl_defined_attribution_unit_res);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] expect_word(tqu_pkg::tqu_req_s q, logic s, logic p);
		logic [31:0] a, w;
		tqu_pkg::tqu_mpu_s m;
		a = q.addr;
		m = (q.variant[1] | ~s) ? (p ? {a[5], a[23:16], 2'h3} : {a[5], a[23:16], a[6], 1'b0})
			: {a[4], a[15:8], 1'b1, p};
		w = '0;
		w[7:0] = m.hit ? m.region : 8'h00;
		w[19:16] = {m.rw_ok, m.read_ok, 1'b0, m.hit};
		if (s) begin
			w[15:8] = a[7] ? a[31:24] : 8'h00;
			w[17] = a[7];
			w[22] = a[1] | a[2];
			w[21:20] = {m.rw_ok, m.read_ok} & {2{~w[22]}};
			w[31:23] = a[3] ? {~a[31:24], 1'b1} : 9'h000;
		end
		return w;
	endfunction : expect_word
	task automatic cmp_flag(string n, logic e, logic g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", n, e, g);
		end
	endtask : cmp_flag
	task automatic cmp_resp(tqu_pkg::tqu_resp_s e, tqu_pkg::tqu_resp_s g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected resp: expected %h seen %h", e, g);
		end
	endtask : cmp_resp
	task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : cmp_word
	// Requester side range decision: same regions at both ends, all asked permissions present.
	function automatic logic range_ok(logic [31:0] ws, logic [31:0] we, logic [2:0] need);
		logic same, perm;
		same = (ws[17:0] == we[17:0]) && (ws[31:23] == we[31:23]);
		perm = ~(need[2] & ~(ws[18] & we[18])) & ~(need[1] & ~(ws[19] & we[19]))
			& ~(need[0] & (ws[22] | we[22]));
		return same & perm;
	endfunction : range_ok
	task automatic query_once(input tqu_pkg::tqu_variant_e v, input logic [31:0] a,
		output logic [31:0] w);
		@(posedge core_clk);
		#1;
		query_valid = 1;
		query_req.variant = v;
		query_req.addr = a;
		query_ctx = 4'hc;
		@(posedge core_clk);
		#1;
		query_valid = 0;
		w = resp.query_response_word;
	endtask : query_once
	// Need bits: read, read-write, non-secure attribution.
	task automatic range_case(tqu_pkg::tqu_variant_e v, logic [31:0] lo, logic [31:0] hi,
		logic [2:0] need, logic e);
		logic [31:0] ws, we;
		query_once(v, lo, ws);
		query_once(v, hi, we);
		cmp_flag("range_ok", e, range_ok(ws, we, need));
	endtask : range_case
	task automatic print_verdict;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'hf238));
		exp_resp = '0;
		repeat (6) @(posedge core_clk);
		#1 reset = 0;
		for (int i = 0; i < 600; i++) begin
			@(posedge core_clk);
			#1;
			cmp_flag("resp_valid", exp_valid, resp_valid);
			cmp_flag("undef_fault", exp_fault, undef_fault);
			cmp_resp(exp_resp, resp);
			query_valid = ($urandom % 4) != 0;
			query_req = 38'({$urandom, $urandom});
			query_ctx = 4'($urandom);
			if (i < 16) begin
				query_valid = 1;
				query_req.variant = tqu_pkg::tqu_variant_e'(i[1:0]);
				query_ctx.secure_state = ~i[2];
			end
			ns = query_req.variant[1] | ~query_ctx.secure_state;
			pv = query_ctx.handler_mode | ~(ns ? query_ctx.unpriv_thread_bit_ns
				: query_ctx.unpriv_thread_bit_s);
			pv = pv & ~query_req.variant[0];
			exp_fault = query_valid & query_req.variant[1] & ~query_ctx.secure_state;
			exp_valid = query_valid & ~exp_fault;
			if (exp_valid)
				exp_resp = {query_req.dest_reg, expect_word(query_req, query_ctx.secure_state, pv)};
			#1;
			cmp_flag("lookup_use_ns_mpu", ns, lookup_use_ns_mpu);
			cmp_word("lookup_addr", query_req.addr, lookup_addr);
			if (query_valid)
				cmp_flag("lookup_priv", pv, lookup_priv);
		end
		@(posedge core_clk);
		#1;
		cmp_flag("resp_valid", exp_valid, resp_valid);
		cmp_flag("undef_fault", exp_fault, undef_fault);
		cmp_resp(exp_resp, resp);
		query_valid = 0;
		range_case(tqu_pkg::TQU_PLAIN, 32'h1234_5610, 32'h1234_5670, 3'h7, 1'b1);
		range_case(tqu_pkg::TQU_PLAIN, 32'h1234_5610, 32'h1234_5710, 3'h4, 1'b0);
		range_case(tqu_pkg::TQU_PLAIN, 32'h1234_5612, 32'h1234_5672, 3'h1, 1'b0);
		range_case(tqu_pkg::TQU_PLAIN, 32'h1234_5612, 32'h1234_5672, 3'h6, 1'b1);
		range_case(tqu_pkg::TQU_UNPRIV, 32'h1234_5610, 32'h1234_5670, 3'h4, 1'b1);
		range_case(tqu_pkg::TQU_UNPRIV, 32'h1234_5610, 32'h1234_5670, 3'h2, 1'b0);
		print_verdict();
	end
endmodule : tqu_target_attribute_query_unit_test
`default_nettype wire
